// >>> pkg/wdt_vmon_params.svh
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDT_VMON_PARAMS_SVH
`define WDT_VMON_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_WATCHDOG_CONTROL 8'h00
`define OFS_RESET_CONTROL_STATUS 8'h04
`define OFS_PERIPHERAL_IRQ_FLAGS_TWO 8'h08
`define OFS_IRQ_STATUS 8'h0c
`define OFS_IRQ_MASK 8'h10

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BIT_SW_WATCHDOG_ENABLE 0
`define BIT_SHARED_SFR_SELECT 4
`define BIT_CORE_VOLTAGE_OK_STATUS 6
`define BIT_REGULATOR_SLEEP_LOWPOWER 7
`define BIT_BROWNOUT_FLAG 0
`define BIT_TIMEOUT_STATUS 3
`define BIT_LOW_VOLTAGE_IRQ_FLAG 2
`define IRQ_LOW_VOLTAGE 0
`define IRQ_TIMEOUT 1
`define IRQ_BROWNOUT 2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_RESET_CONTROL_STATUS 8'h09
`define RST_IRQ_MASK 3'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_FREQ_MHZ 40
`define WDT_BASE_PERIOD_US 4000
`define WDT_BASE_CYCLES (`WDT_BASE_PERIOD_US * `CLK_FREQ_MHZ)
`define REG_STABILIZE_US 20
`define REG_STABILIZE_CYCLES (`REG_STABILIZE_US * `CLK_FREQ_MHZ)

`endif

// >>> pkg/wdt_vmon_pkg.sv
// Types shared by the watchdog and core voltage monitor block
package wdt_vmon_pkg;

    // ---------------------------------------------------------------
    // Wishbone classic request carrier
    // ---------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    // Power state of the core as seen by the wake-up logic
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_STABILIZE
    } power_state_e;

endpackage

// >>> rtl/wdt_vmon.sv
// Watchdog timer with core voltage monitor and Wishbone register slave
//
// The register offsets and register access over Wishbone are this design's own decisions.
`include "wdt_vmon_params.svh"

// Operation
// - Watchdog runs on RC time; enabling starts oscillator
// - Base watchdog period is nominally 4 ms
// - Base period feeds 16-bit postscaler, selectable tap
// - Scale code n divides by two to n
// - Sleep, clear instruction, clock failure clear counters
// - Control bit 0 is software enable, resets 0
// - Configuration enable forces watchdog on
// - Control bit 7 selects regulator low-power sleep
// - Low-voltage detect clears regulator low-power bit
// - Low-power sleep delays wake for regulator stabilizing
// - Control bit 6 shows live core voltage status
// - Voltage status and detection need regulator enabled
// - Core supply drop sets low-voltage flag bit 2
// - Low-voltage flag sets once per falling crossing
// - Device reset clears low-voltage flag
// - Control bit 4 selects shared register set
// - Control bits 5 and 3:1 read zero
// - Regulator dropout causes brown-out reset, flag recorded
module wdt_vmon #(
    parameter logic [17:0] BASE_CYCLES = 18'(`WDT_BASE_CYCLES)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wdt_vmon_pkg::wb_req_s wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic cfg_watchdog_enable_i,
    input wire logic [3:0] timeout_scale_select_i,
    input wire logic sleep_instr_i,
    input wire logic clear_watchdog_instr_i,
    input wire logic clock_fail_i,
    input wire logic wake_request_i,
    input wire logic regulator_enable_i,
    input wire logic core_supply_ok_i,
    input wire logic regulator_dropout_i,
    output logic internal_rc_oscillator_on_o,
    output logic device_reset_o,
    output logic regulator_lowpower_sleep_o,
    output logic shared_sfr_select_o,
    output logic exec_enable_o,
    output logic irq_o
);
    import wdt_vmon_pkg::*;

    localparam logic [11:0] STAB_CYCLES = 12'(`REG_STABILIZE_CYCLES);

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------

    // Terminal postscaler count for a scale code: two to the code, minus one
    function automatic logic [15:0] scale_mask(input logic [3:0] code);
        scale_mask = 16'((17'h1 << code) - 17'h1);
    endfunction

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic cfg_en_s;
    logic [3:0] scale_sel_s;
    logic reg_en_s;
    logic core_ok_s;
    logic dropout_s;

    // Two flip-flops on every pin that comes from outside the clock domain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= 8'h00;
            sync_b <= 8'h00;
        end else begin
            sync_a <= {core_supply_ok_i, regulator_dropout_i, regulator_enable_i,
                       timeout_scale_select_i, cfg_watchdog_enable_i};
            sync_b <= sync_a;
        end
    end

    assign cfg_en_s = sync_b[0];
    assign scale_sel_s = sync_b[4:1];
    assign reg_en_s = sync_b[5];
    assign dropout_s = sync_b[6];
    assign core_ok_s = sync_b[7];

    // ---------------------------------------------------------------
    // Register state and bus decode
    // ---------------------------------------------------------------
    logic sw_en;
    logic shared_sel;
    logic lp_sleep_en;
    logic [7:0] rst_status;
    logic lv_flag;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic bus_req;
    logic wr_stb;
    logic rd_stb;
    logic lane0;
    logic [31:0] next_rdata;

    // A new access is taken only while no acknowledge is pending
    assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
    assign wr_stb = bus_req & wb_req_i.we;
    assign rd_stb = bus_req & ~wb_req_i.we;
    assign lane0 = wb_req_i.sel[0];

    // ---------------------------------------------------------------
    // Voltage monitor events
    // ---------------------------------------------------------------
    logic core_ok_d;
    logic dropout_d;
    logic lv_fall;
    logic bo_rise;

    // Previous levels for edge detection on synchronised signals
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_ok_d <= 1'b1;
            dropout_d <= 1'b0;
        end else begin
            core_ok_d <= core_ok_s;
            dropout_d <= dropout_s;
        end
    end

    // Falling crossing of the core supply, seen only with the regulator on
    assign lv_fall = reg_en_s & core_ok_d & ~core_ok_s;
    assign bo_rise = reg_en_s & dropout_s & ~dropout_d;

    // ---------------------------------------------------------------
    // Watchdog counters
    // ---------------------------------------------------------------
    logic running;
    logic [17:0] base_cnt;
    logic [15:0] post_cnt;
    logic base_tick;
    logic wdt_clear;
    logic timeout_evt;

    assign running = cfg_en_s | sw_en;
    assign base_tick = running & (base_cnt == BASE_CYCLES - 18'h1);
    assign wdt_clear = sleep_instr_i | clear_watchdog_instr_i | clock_fail_i;
    assign timeout_evt = base_tick & ~wdt_clear
                         & (post_cnt == scale_mask(scale_sel_s));

    // Base divider of the oscillator time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_cnt <= 18'h0;
        end else if (wdt_clear || !running || base_tick || device_reset_o) begin
            base_cnt <= 18'h0;
        end else begin
            base_cnt <= base_cnt + 18'h1;
        end
    end

    // Postscaler counts base periods; restarts on every clear and expiry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            post_cnt <= 16'h0;
        end else if (wdt_clear || !running || timeout_evt || device_reset_o) begin
            post_cnt <= 16'h0;
        end else if (base_tick) begin
            post_cnt <= post_cnt + 16'h1;
        end
    end

    // Oscillator runs whenever the watchdog is enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            internal_rc_oscillator_on_o <= 1'b0;
        end else begin
            internal_rc_oscillator_on_o <= running;
        end
    end

    // Device reset pulse from watchdog expiry or brown-out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            device_reset_o <= 1'b0;
        end else begin
            device_reset_o <= timeout_evt | bo_rise;
        end
    end

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------
    logic ctrl_wr;

    assign ctrl_wr = wr_stb & lane0 & (wb_req_i.adr == `OFS_WATCHDOG_CONTROL);

    // Software enable and shared register select; cleared by any reset
    always_ff @(posedge clk_i) begin
        if (rst_i || device_reset_o) begin
            sw_en <= 1'b0;
            shared_sel <= 1'b0;
        end else if (ctrl_wr) begin
            sw_en <= wb_req_i.dat[`BIT_SW_WATCHDOG_ENABLE];
            shared_sel <= wb_req_i.dat[`BIT_SHARED_SFR_SELECT];
        end
    end

    // Regulator low-power bit; a low-voltage event beats a software write
    always_ff @(posedge clk_i) begin
        if (rst_i || device_reset_o) begin
            lp_sleep_en <= 1'b0;
        end else if (lv_fall) begin
            lp_sleep_en <= 1'b0;
        end else if (ctrl_wr) begin
            lp_sleep_en <= wb_req_i.dat[`BIT_REGULATOR_SLEEP_LOWPOWER];
        end
    end

    // ---------------------------------------------------------------
    // Reset status and low-voltage flag
    // ---------------------------------------------------------------
    logic rcs_wr;
    logic pir_wr;

    assign rcs_wr = wr_stb & lane0 & (wb_req_i.adr == `OFS_RESET_CONTROL_STATUS);
    assign pir_wr = wr_stb & lane0 & (wb_req_i.adr == `OFS_PERIPHERAL_IRQ_FLAGS_TWO);

    // Status bits are low after their event; a software write re-arms them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_status <= `RST_RESET_CONTROL_STATUS;
        end else begin
            if (rcs_wr) begin
                rst_status <= wb_req_i.dat[7:0] & `RST_RESET_CONTROL_STATUS;
            end
            if (timeout_evt) begin
                rst_status[`BIT_TIMEOUT_STATUS] <= 1'b0;
            end
            if (bo_rise) begin
                rst_status[`BIT_BROWNOUT_FLAG] <= 1'b0;
            end
        end
    end

    // Low-voltage flag: set on a falling crossing, cleared by software or reset
    always_ff @(posedge clk_i) begin
        if (rst_i || device_reset_o) begin
            lv_flag <= 1'b0;
        end else if (lv_fall) begin
            lv_flag <= 1'b1;
        end else if (pir_wr && !wb_req_i.dat[`BIT_LOW_VOLTAGE_IRQ_FLAG]) begin
            lv_flag <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt status, mask and output
    // ---------------------------------------------------------------
    logic irq_rd;
    logic [2:0] irq_events;

    assign irq_rd = rd_stb & (wb_req_i.adr == `OFS_IRQ_STATUS);
    assign irq_events = {bo_rise, timeout_evt, lv_fall};

    // Sticky events; a read clears them, but a coincident event survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= 3'h0;
        end else if (irq_rd) begin
            irq_status <= irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    // Mask register, one enable per status bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= `RST_IRQ_MASK;
        end else if (wr_stb && lane0 && wb_req_i.adr == `OFS_IRQ_MASK) begin
            irq_mask <= wb_req_i.dat[2:0];
        end
    end

    // Level interrupt from the registered status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // ---------------------------------------------------------------
    // Sleep and wake-up sequencing
    // ---------------------------------------------------------------
    power_state_e pwr_state;
    logic [11:0] stab_cnt;

    // Low-power sleep adds a regulator stabilizing wait before execution
    always_ff @(posedge clk_i) begin
        if (rst_i || device_reset_o) begin
            pwr_state <= PWR_RUN;
            stab_cnt <= 12'h0;
        end else begin
            case (pwr_state)
                PWR_RUN: begin
                    if (sleep_instr_i) begin
                        pwr_state <= PWR_SLEEP;
                    end
                end
                PWR_SLEEP: begin
                    if (wake_request_i && lp_sleep_en) begin
                        pwr_state <= PWR_STABILIZE;
                        stab_cnt <= 12'h0;
                    end else if (wake_request_i) begin
                        pwr_state <= PWR_RUN;
                    end
                end
                PWR_STABILIZE: begin
                    if (stab_cnt == STAB_CYCLES - 12'h1) begin
                        pwr_state <= PWR_RUN;
                    end else begin
                        stab_cnt <= stab_cnt + 12'h1;
                    end
                end
                default: begin
                    pwr_state <= PWR_RUN;
                end
            endcase
        end
    end

    // Pin-level outputs of the power sequencer and control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exec_enable_o <= 1'b1;
            regulator_lowpower_sleep_o <= 1'b0;
            shared_sfr_select_o <= 1'b0;
        end else begin
            exec_enable_o <= (pwr_state == PWR_RUN);
            regulator_lowpower_sleep_o <= lp_sleep_en & (pwr_state == PWR_SLEEP);
            shared_sfr_select_o <= shared_sel;
        end
    end

    // ---------------------------------------------------------------
    // Read mux and acknowledge
    // ---------------------------------------------------------------

    // Unmapped offsets and reserved bits read as zero
    always_comb begin
        next_rdata = 32'h0;
        case (wb_req_i.adr)
            `OFS_WATCHDOG_CONTROL: begin
                next_rdata[`BIT_REGULATOR_SLEEP_LOWPOWER] = lp_sleep_en;
                next_rdata[`BIT_CORE_VOLTAGE_OK_STATUS] = core_ok_s & reg_en_s;
                next_rdata[`BIT_SHARED_SFR_SELECT] = shared_sel;
                next_rdata[`BIT_SW_WATCHDOG_ENABLE] = sw_en;
            end
            `OFS_RESET_CONTROL_STATUS: begin
                next_rdata[7:0] = rst_status;
            end
            `OFS_PERIPHERAL_IRQ_FLAGS_TWO: begin
                next_rdata[`BIT_LOW_VOLTAGE_IRQ_FLAG] = lv_flag;
            end
            `OFS_IRQ_STATUS: begin
                next_rdata[2:0] = irq_status;
            end
            `OFS_IRQ_MASK: begin
                next_rdata[2:0] = irq_mask;
            end
            default: begin
                next_rdata = 32'h0;
            end
        endcase
    end

    // One acknowledge per access, registered one cycle after the request and dropped the following cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            if (rd_stb) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_RC_FOLLOWS: assert property (running |=> internal_rc_oscillator_on_o)
        else $error("oscillator off while watchdog enabled");
    AST_CFG_FORCES: assert property (cfg_en_s |-> ##1 internal_rc_oscillator_on_o)
        else $error("configuration enable did not run watchdog");
    AST_BASE_WRAP: assert property (base_tick |=> base_cnt == 18'h0)
        else $error("base divider did not wrap at its period");
    AST_EXPIRE_TAP: assert property (timeout_evt |-> post_cnt == scale_mask(scale_sel_s))
        else $error("expiry at wrong postscaler tap");
    AST_CLEAR: assert property (wdt_clear |=> base_cnt == 18'h0 && post_cnt == 16'h0)
        else $error("counters not cleared");
    AST_TIMEOUT: assert property (timeout_evt |=> device_reset_o
                                  && !rst_status[`BIT_TIMEOUT_STATUS])
        else $error("expiry without reset and status");
    AST_SWEN_OFF: assert property (device_reset_o |=> !sw_en && !lv_flag
                                   && !lp_sleep_en)
        else $error("reset did not clear control and flag");
    AST_LV_EVENT: assert property (lv_fall && !device_reset_o |=> lv_flag
                                   && !lp_sleep_en)
        else $error("low-voltage event not recorded");
    AST_LV_ONCE: assert property ($fell(lv_flag) && !core_ok_s && !$past(core_ok_s)
                                  ##1 !core_ok_s |-> !lv_flag)
        else $error("low-voltage flag set again without crossing");
    AST_UNIMPL: assert property (wb_ack_o && $past(rd_stb)
                                 && $past(wb_req_i.adr) == `OFS_WATCHDOG_CONTROL
                                 |-> wb_dat_o[5] == 1'b0 && wb_dat_o[3:1] == 3'h0)
        else $error("unimplemented control bits not zero");
    AST_STATUS_LIVE: assert property (wb_ack_o && $past(rd_stb)
                                      && $past(wb_req_i.adr) == `OFS_WATCHDOG_CONTROL
                                      |-> wb_dat_o[6] == $past(core_ok_s & reg_en_s))
        else $error("core voltage status not live");
    AST_BROWNOUT: assert property (bo_rise |=> device_reset_o
                                   && !rst_status[`BIT_BROWNOUT_FLAG])
        else $error("brown-out not recorded");
    AST_STAB_WAIT: assert property (pwr_state == PWR_SLEEP && wake_request_i
                                    && lp_sleep_en && !device_reset_o
                                    |=> !exec_enable_o [*8])
        else $error("wake not delayed for regulator");
    AST_LOWPOWER: assert property (pwr_state == PWR_SLEEP && lp_sleep_en
                                   |=> regulator_lowpower_sleep_o)
        else $error("regulator not in low power during sleep");
    AST_SHARED: assert property (ctrl_wr && !device_reset_o
                                 |=> ##1 shared_sfr_select_o == $past(wb_req_i.dat[4], 2))
        else $error("shared select not applied");

    COV_TIMEOUT: cover property (timeout_evt);
    COV_LV_IRQ: cover property (lv_fall ##[1:50] irq_o);
    COV_STAB_WAKE: cover property (pwr_state == PWR_STABILIZE ##1 pwr_state == PWR_RUN);
    COV_BROWNOUT: cover property (bo_rise);

endmodule

// >>> verif/tb_wdt_vmon.sv
// Self-checking testbench of the watchdog and core voltage monitor block
`include "wdt_vmon_params.svh"
module tb_wdt_vmon;
timeunit 1ns;
timeprecision 1ps;
import wdt_vmon_pkg::*;
// ---------------------------------------------------------------
// Signals
// ---------------------------------------------------------------
localparam int BASE = 16;
logic clk_i = 1'b0;
logic rst_i = 1'b1;
wb_req_s req = '0;
logic ack, osc_on, dev_rst, lp, shared, exec_en, irq;
logic [31:0] dat, rd;
logic cfg_en = 1'b0, clr = 1'b0, slp = 1'b0, cfail = 1'b0, wake = 1'b0;
logic reg_en = 1'b0, core_ok = 1'b1, drop = 1'b0;
logic [3:0] scale = 4'h0;
logic [31:0] seed = 32'd87348;
int n_fail = 0, total_checks = 0, n_rst = 0, n, e;
wdt_vmon #(.BASE_CYCLES(18'(BASE))) wdt_vmon_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(dat), .cfg_watchdog_enable_i(cfg_en),
    .timeout_scale_select_i(scale), .sleep_instr_i(slp), .clear_watchdog_instr_i(clr),
    .clock_fail_i(cfail), .wake_request_i(wake), .regulator_enable_i(reg_en),
    .core_supply_ok_i(core_ok), .regulator_dropout_i(drop),
    .internal_rc_oscillator_on_o(osc_on), .device_reset_o(dev_rst),
    .regulator_lowpower_sleep_o(lp), .shared_sfr_select_o(shared),
    .exec_enable_o(exec_en), .irq_o(irq));
// Clock at 40 MHz
initial begin
    forever #12.5 clk_i = ~clk_i;
end
// Counts device reset pulses
always @(posedge clk_i) begin
    if (dev_rst === 1'b1) n_rst <= n_rst + 1;
end
// ---------------------------------------------------------------
// Helpers
// ---------------------------------------------------------------
function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
// Expected control read: unused bits zero, status bit live
function logic [31:0] exp_ctrl(input logic [7:0] w, input logic ok);
    return {24'h0, w[7], ok, 1'b0, w[4], 3'b000, w[0]};
endfunction
task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
        $display("BAD %s expected %h seen %h", what, exp, got);
        n_fail++;
    end
endtask
task cyc(input int k);
    repeat (k) @(posedge clk_i);
endtask
// Classic single cycle, held until ack is sampled high
task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    @(posedge clk_i);
    while (ack !== 1'b1) begin
        @(posedge clk_i);
        w++;
    end
    chk("bus ack latency", 1, w == 1);
    rd = dat;
    req <= '0;
endtask
task rchk(input logic [7:0] a, input logic [31:0] ex, input string what);
    wb(1'b0, a, 32'h0);
    chk(what, ex, rd);
endtask
// One-cycle pulse: 0 clear, 1 sleep, 2 clock failure, 3 wake
task pulse(input int k);
    clr <= (k == 0);
    slp <= (k == 1);
    cfail <= (k == 2);
    wake <= (k == 3);
    @(posedge clk_i);
    {clr, slp, cfail, wake} <= 4'h0;
endtask
task close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask
// Watchdog against hangs
initial begin
    #(25 * 12000);
    n_fail++;
    close_out();
end
// ---------------------------------------------------------------
// Main sequence
// ---------------------------------------------------------------
initial begin
    logic [7:0] d;
    cyc(2);
    rst_i <= 1'b0;
    rchk(`OFS_WATCHDOG_CONTROL, 32'h0, "ctrl reset");
    rchk(`OFS_RESET_CONTROL_STATUS, 32'h09, "status reset");
    rchk(8'h14, 32'h0, "unmapped read");
    d = 8'(xs()) & 8'hfe;
    wb(1'b1, `OFS_WATCHDOG_CONTROL, {24'h0, d});
    rchk(`OFS_WATCHDOG_CONTROL, exp_ctrl(d, 1'b0), "ctrl rw");
    chk("shared select", d[4], shared);
    wb(1'b1, `OFS_WATCHDOG_CONTROL, 32'h0);
    // Timeout period for random scale codes 0 to 2, last pass code 0 by configuration enable
    for (int i = 0; i < 4; i++) begin
        scale <= (i == 3) ? 4'h0 : 4'(xs() % 3);
        cyc(4);
        if (i == 3) cfg_en <= 1'b1;
        else wb(1'b1, `OFS_WATCHDOG_CONTROL, 32'h01);
        cyc(4);
        chk("osc on", 1, osc_on);
        for (n = 4; n < 2000 && dev_rst !== 1'b1; n++) @(posedge clk_i);
        cfg_en <= 1'b0;
        e = BASE << scale;
        chk("watchdog period", 1, n >= e - 2 && n <= e + 6);
        rchk(`OFS_RESET_CONTROL_STATUS, 32'h01, "timeout status");
        rchk(`OFS_WATCHDOG_CONTROL, 32'h0, "ctrl after reset");
        wb(1'b1, `OFS_RESET_CONTROL_STATUS, 32'h09);
    end
    // Clear sources keep the watchdog from expiring
    scale <= 4'h0;
    cyc(4);
    wb(1'b1, `OFS_WATCHDOG_CONTROL, 32'h01);
    e = n_rst;
    for (int k = 0; k < 12; k++) begin
        cyc(8);
        pulse(k % 3);
        if (k % 3 == 1) begin
            cyc(1);
            pulse(3);
        end
    end
    chk("no expiry", e, n_rst);
    wb(1'b1, `OFS_WATCHDOG_CONTROL, 32'h80);
    // Low-power sleep delays wake-up
    pulse(1);
    cyc(3);
    chk("exec in sleep", 0, exec_en);
    chk("lowpower in sleep", 1, lp);
    pulse(3);
    cyc(10);
    chk("exec stabilizing", 0, exec_en);
    cyc(`REG_STABILIZE_CYCLES);
    chk("exec after wake", 1, exec_en);
    // Low-voltage flag, interrupt and regulator bit
    reg_en <= 1'b1;
    cyc(4);
    rchk(`OFS_WATCHDOG_CONTROL, 32'hc0, "core ok status");
    wb(1'b1, `OFS_IRQ_MASK, 32'h7);
    wb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    core_ok <= 1'b0;
    cyc(6);
    chk("irq raised", 1, irq);
    rchk(`OFS_PERIPHERAL_IRQ_FLAGS_TWO, 32'h04, "lv flag");
    rchk(`OFS_WATCHDOG_CONTROL, 32'h0, "regulator_sleep_lowpower cleared");
    rchk(`OFS_IRQ_STATUS, 32'h01, "irq status");
    rchk(`OFS_IRQ_STATUS, 32'h0, "irq status cleared");
    chk("irq cleared", 0, irq);
    wb(1'b1, `OFS_PERIPHERAL_IRQ_FLAGS_TWO, 32'h0);
    rchk(`OFS_PERIPHERAL_IRQ_FLAGS_TWO, 32'h0, "lv no reset");
    core_ok <= 1'b1;
    cyc(6);
    core_ok <= 1'b0;
    cyc(6);
    rchk(`OFS_PERIPHERAL_IRQ_FLAGS_TWO, 32'h04, "lv new edge");
    wb(1'b1, `OFS_PERIPHERAL_IRQ_FLAGS_TWO, 32'h0);
    // Regulator disabled: no status, no detection
    core_ok <= 1'b1;
    reg_en <= 1'b0;
    cyc(4);
    rchk(`OFS_WATCHDOG_CONTROL, 32'h0, "status off");
    core_ok <= 1'b0;
    cyc(6);
    rchk(`OFS_PERIPHERAL_IRQ_FLAGS_TWO, 32'h0, "lv off");
    reg_en <= 1'b1;
    core_ok <= 1'b1;
    cyc(6);
    wb(1'b1, `OFS_IRQ_MASK, 32'h0);
    core_ok <= 1'b0;
    cyc(6);
    chk("irq masked", 0, irq);
    // Brown-out resets and clears the flag while supply stays low
    drop <= 1'b1;
    for (n = 0; n < 20 && dev_rst !== 1'b1; n++) @(posedge clk_i);
    chk("brownout reset", 1, n < 20);
    drop <= 1'b0;
    cyc(2);
    rchk(`OFS_PERIPHERAL_IRQ_FLAGS_TWO, 32'h0, "lv after reset");
    rchk(`OFS_RESET_CONTROL_STATUS, 32'h08, "brownout flag");
    close_out();
end
endmodule
